/* File: hdl/bcc_pkg.sv */
// What this block does
// - zero branch: fixed upper byte, signed offset
// - zero set: counter plus twice offset
// - taken two cycles, else one; flags untouched
// - call pushes address plus four, loads target
// - shadow bit copies accumulator, status, bank
// - call two words; target written last phase
// - clear writes zero, sets zero flag
// - access bit picks access bank or bank
// - extended set, low addresses use indexed offset
// - watchdog clear resets counter, sets two flags
// - invert all bits, only negative/zero flags
// - destination bit picks accumulator or register
// - equal compare skips next instruction
// - unsigned greater compare skips next
// - unsigned less compare skips next
// - compare subtracts, stores nothing, flags untouched
// - skip runs no-op; three cycles for two-word
package bcc_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int PC_W    = 21;
  localparam int DATA_W  = 8;
  localparam int DADDR_W = 12;
  localparam int WORD_W  = 16;
  localparam int BANK_W  = 4;
  localparam int RADDR_W = 3;

  // ****************************************
  // encodings and fields
  // ****************************************
  localparam logic [7:0]  OPC_BRANCH_ZERO = 8'hE0;
  localparam logic [6:0]  OPC_CALL        = 7'h76;
  localparam logic [6:0]  OPC_REG_CLEAR   = 7'h35;
  localparam logic [6:0]  OPC_CMP_EQ      = 7'h31;
  localparam logic [6:0]  OPC_CMP_GT      = 7'h32;
  localparam logic [6:0]  OPC_CMP_LT      = 7'h30;
  localparam logic [5:0]  OPC_REG_INVERT  = 6'h07;
  localparam logic [15:0] OPC_WDT_CLEAR   = 16'h0004;
  localparam logic [15:0] OPC_NOP         = 16'h0000;
  localparam logic [3:0]  OPC_MOVE_PAIR   = 4'hC;
  localparam int          BIT_ACCESS      = 8;
  localparam int          BIT_SHADOW      = 8;
  localparam int          BIT_DEST        = 9;
  localparam int          CALL_HI_MSB     = 11;

  // ****************************************
  // addressing
  // ****************************************
  localparam logic [7:0]        IDX_LIMIT      = 8'h5F;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;

  // ****************************************
  // register port map and reset values
  // ****************************************
  localparam logic [RADDR_W-1:0] REG_ACC       = 3'h0;
  localparam logic [RADDR_W-1:0] REG_STATUS    = 3'h1;
  localparam logic [RADDR_W-1:0] REG_BANK      = 3'h2;
  localparam logic [RADDR_W-1:0] REG_CTRL      = 3'h3;
  localparam logic [RADDR_W-1:0] REG_ACC_SH    = 3'h4;
  localparam logic [RADDR_W-1:0] REG_STATUS_SH = 3'h5;
  localparam logic [RADDR_W-1:0] REG_BANK_SH   = 3'h6;
  localparam logic [RADDR_W-1:0] REG_WDT_FLAGS = 3'h7;
  localparam int                 CTRL_EXT_BIT  = 0;
  localparam logic [PC_W-1:0]    PC_RESET      = 21'h0_0000;
  localparam logic [PC_W-1:0]    PC_STEP       = 21'h0_0002;
  localparam logic [DATA_W-1:0]  DATA_ZERO     = 8'h00;
  localparam logic [BANK_W-1:0]  BANK_RESET    = 4'h0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } bcc_phase_t;

  typedef enum logic [3:0] {
    OP_NONE         = 4'b0000,
    OP_BRANCH_ZERO  = 4'b0001,
    OP_CALL         = 4'b0010,
    OP_REG_CLEAR    = 4'b0011,
    OP_WDT_CLEAR    = 4'b0100,
    OP_REG_INVERT   = 4'b0101,
    OP_CMP_EQ       = 4'b0110,
    OP_CMP_GT       = 4'b0111,
    OP_CMP_LT       = 4'b1000
  } bcc_op_t;

  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic dcarry;
    logic carry;
  } bcc_status_t;

  typedef struct packed {
    logic               we;
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0]  data;
  } bcc_dwrite_t;

  typedef struct packed {
    logic            push;
    logic [PC_W-1:0] addr;
  } bcc_push_t;

  localparam bcc_status_t STATUS_RESET = 5'h00;

endpackage : bcc_pkg

/* File: hdl/bcc_addr_sel.sv */
`timescale 1ns/1ps
module bcc_addr_sel
  import bcc_pkg::*;
(
  input  wire logic [7:0]                  fileAddr,
  input  wire logic                        accessBit,
  input  wire logic [bcc_pkg::BANK_W-1:0]  bankSel,
  input  wire logic                        extEnable,
  input  wire logic [bcc_pkg::DADDR_W-1:0] indexBase,
  output logic      [bcc_pkg::DADDR_W-1:0] dataAddr
);
  // ****************************************
  // bank and offset selection
  // ****************************************
  always_comb
  begin
    if (accessBit)
    begin
      dataAddr = {bankSel, fileAddr};
    end
    else if (fileAddr <= IDX_LIMIT)
    begin
      if (extEnable)
      begin
        dataAddr = indexBase + {4'h0, fileAddr};
      end
      else
      begin
        dataAddr = {ACCESS_LO_BANK, fileAddr};
      end
    end
    else
    begin
      dataAddr = {ACCESS_HI_BANK, fileAddr};
    end
  end

endmodule : bcc_addr_sel

/* File: hdl/bcc_alu.sv */
`timescale 1ns/1ps
module bcc_alu
  import bcc_pkg::*;
(
  input  wire logic [bcc_pkg::DATA_W-1:0] operand,
  input  wire logic [bcc_pkg::DATA_W-1:0] acc,
  input  wire bcc_pkg::bcc_op_t           op,
  output logic      [bcc_pkg::DATA_W-1:0] result,
  output logic                            resNeg,
  output logic                            resZero,
  output logic                            skip
);
  logic [DATA_W:0] diff;

  // ****************************************
  // invert and unsigned compare
  // ****************************************
  always_comb
  begin
    result  = ~operand;
    resNeg  = result[DATA_W-1];
    resZero = (result == DATA_ZERO);
    // borrow out of the subtraction marks operand below accumulator
    diff    = {1'b0, operand} - {1'b0, acc};
    unique case (op)
      OP_CMP_EQ: skip = (diff[DATA_W-1:0] == DATA_ZERO);
      OP_CMP_GT: skip = !diff[DATA_W] &&
                        (diff[DATA_W-1:0] != DATA_ZERO);
      OP_CMP_LT: skip = diff[DATA_W];
      default:   skip = 1'b0;
    endcase
  end

endmodule : bcc_alu

/* File: hdl/bcc_core_exec.sv */
`timescale 1ns/1ps
module bcc_core_exec
  import bcc_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // program memory
  output logic      [bcc_pkg::PC_W-1:0]    progAddr,
  input  wire logic [bcc_pkg::WORD_W-1:0]  progData,
  // data memory
  output logic      [bcc_pkg::DADDR_W-1:0] dataAddr,
  input  wire logic [bcc_pkg::DATA_W-1:0]  dataRdata,
  output bcc_pkg::bcc_dwrite_t             dataWrite,
  input  wire logic [bcc_pkg::DADDR_W-1:0] indexBase,
  // return stack and watchdog
  output bcc_pkg::bcc_push_t               stackPush,
  output logic                             wdtClear,
  // register port
  input  wire logic [bcc_pkg::RADDR_W-1:0] regAddr,
  input  wire logic [bcc_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [bcc_pkg::DATA_W-1:0]  regRdata
);
  import bcc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  bcc_phase_t          phase_reg,      phase_next;
  logic [PC_W-1:0]     pc_reg,         pc_next;
  logic [WORD_W-1:0]   instr_reg,      instr_next;
  logic [DATA_W-1:0]   acc_reg,        acc_next;
  bcc_status_t         status_reg,     status_next;
  logic [BANK_W-1:0]   bank_reg,       bank_next;
  logic                extEn_reg,      extEn_next;
  logic [DATA_W-1:0]   accSh_reg,      accSh_next;
  bcc_status_t         statusSh_reg,   statusSh_next;
  logic [BANK_W-1:0]   bankSh_reg,     bankSh_next;
  logic                timeout_reg,    timeout_next;
  logic                powerdown_reg,  powerdown_next;
  logic                taken_reg,      taken_next;
  logic                skip_reg,       skip_next;
  logic                skipSecond_reg, skipSecond_next;
  logic [DADDR_W-1:0]  dataAddr_reg,   dataAddr_next;
  bcc_dwrite_t         dataWrite_reg,  dataWrite_next;
  bcc_push_t           push_reg,       push_next;
  logic                wdtClear_reg,   wdtClear_next;
  logic [DATA_W-1:0]   regRdata_reg,   regRdata_next;

  bcc_op_t             op;
  logic [DADDR_W-1:0]  selAddr;
  logic [DATA_W-1:0]   aluResult;
  logic                aluNeg;
  logic                aluZero;
  logic                aluSkip;
  logic [PC_W-1:0]     branchOffset;

  // ****************************************
  // decode
  // ****************************************
  function automatic bcc_op_t decodeOp(input logic [WORD_W-1:0] w);
    bcc_op_t k;
    k = OP_NONE;
    if (w[15:8] == OPC_BRANCH_ZERO)
    begin
      k = OP_BRANCH_ZERO;
    end
    else if (w[15:9] == OPC_CALL)
    begin
      k = OP_CALL;
    end
    else if (w[15:9] == OPC_REG_CLEAR)
    begin
      k = OP_REG_CLEAR;
    end
    else if (w == OPC_WDT_CLEAR)
    begin
      k = OP_WDT_CLEAR;
    end
    else if (w[15:10] == OPC_REG_INVERT)
    begin
      k = OP_REG_INVERT;
    end
    else if (w[15:9] == OPC_CMP_EQ)
    begin
      k = OP_CMP_EQ;
    end
    else if (w[15:9] == OPC_CMP_GT)
    begin
      k = OP_CMP_GT;
    end
    else if (w[15:9] == OPC_CMP_LT)
    begin
      k = OP_CMP_LT;
    end
    return k;
  endfunction : decodeOp

  // first word of a two-word instruction
  function automatic logic isTwoWord(input logic [WORD_W-1:0] w);
    return (w[15:12] == OPC_MOVE_PAIR) || (w[15:9] == OPC_CALL);
  endfunction : isTwoWord

  always_comb
  begin
    op           = decodeOp(instr_reg);
    branchOffset = {{(PC_W-9){instr_reg[7]}}, instr_reg[7:0], 1'b0};
  end

  // ****************************************
  // operand address and data path
  // ****************************************
  bcc_addr_sel u_addr_sel (
    .fileAddr  (instr_reg[7:0]),
    .accessBit (instr_reg[BIT_ACCESS]),
    .bankSel   (bank_reg),
    .extEnable (extEn_reg),
    .indexBase (indexBase),
    .dataAddr  (selAddr)
  );

  bcc_alu u_alu (
    .operand (dataRdata),
    .acc     (acc_reg),
    .op      (op),
    .result  (aluResult),
    .resNeg  (aluNeg),
    .resZero (aluZero),
    .skip    (aluSkip)
  );

  // ****************************************
  // instruction cycle: Q1 address, Q3 process, Q4 program counter
  // ****************************************
  always_comb
  begin
    phase_next      = bcc_phase_t'(phase_reg + 2'b01);
    pc_next         = pc_reg;
    instr_next      = instr_reg;
    acc_next        = acc_reg;
    status_next     = status_reg;
    bank_next       = bank_reg;
    extEn_next      = extEn_reg;
    accSh_next      = accSh_reg;
    statusSh_next   = statusSh_reg;
    bankSh_next     = bankSh_reg;
    timeout_next    = timeout_reg;
    powerdown_next  = powerdown_reg;
    taken_next      = taken_reg;
    skip_next       = skip_reg;
    skipSecond_next = skipSecond_reg;
    dataAddr_next   = dataAddr_reg;
    dataWrite_next  = '0;
    push_next       = '0;
    wdtClear_next   = 1'b0;

    // software writes; the instruction path below overrides them
    if (regWr)
    begin
      unique case (regAddr)
        REG_ACC:       acc_next      = regWdata;
        REG_STATUS:    status_next   = regWdata[4:0];
        REG_BANK:      bank_next     = regWdata[BANK_W-1:0];
        REG_CTRL:      extEn_next    = regWdata[CTRL_EXT_BIT];
        REG_ACC_SH:    accSh_next    = regWdata;
        REG_STATUS_SH: statusSh_next = regWdata[4:0];
        REG_BANK_SH:   bankSh_next   = regWdata[BANK_W-1:0];
        REG_WDT_FLAGS: ;
      endcase
    end

    unique case (phase_reg)
      PH_Q1:
      begin
        dataAddr_next = selAddr;
        taken_next    = 1'b0;
        skip_next     = 1'b0;
      end
      PH_Q2: ;
      PH_Q3:
      begin
        unique case (op)
          OP_BRANCH_ZERO:
          begin
            taken_next = status_reg.zero;
          end
          OP_CALL:
          begin
            push_next.push = 1'b1;
            push_next.addr = pc_reg + PC_STEP;
            if (instr_reg[BIT_SHADOW])
            begin
              accSh_next    = acc_reg;
              statusSh_next = status_reg;
              bankSh_next   = bank_reg;
            end
          end
          OP_REG_CLEAR:
          begin
            dataWrite_next = {1'b1, dataAddr_reg, DATA_ZERO};
            status_next.zero = 1'b1;
          end
          OP_WDT_CLEAR:
          begin
            wdtClear_next  = 1'b1;
            timeout_next   = 1'b1;
            powerdown_next = 1'b1;
          end
          OP_REG_INVERT:
          begin
            if (instr_reg[BIT_DEST])
            begin
              dataWrite_next = {1'b1, dataAddr_reg, aluResult};
            end
            else
            begin
              acc_next = aluResult;
            end
            status_next.neg  = aluNeg;
            status_next.zero = aluZero;
          end
          OP_CMP_EQ, OP_CMP_GT, OP_CMP_LT:
          begin
            skip_next = aluSkip;
          end
          OP_NONE: ;
        endcase
      end
      PH_Q4:
      begin
        pc_next    = pc_reg + PC_STEP;
        instr_next = progData;
        if (skipSecond_reg)
        begin
          // second word of a skipped two-word instruction
          instr_next      = OPC_NOP;
          skipSecond_next = 1'b0;
        end
        if (op == OP_CALL)
        begin
          pc_next    = {progData[CALL_HI_MSB:0], instr_reg[7:0], 1'b0};
          instr_next = OPC_NOP;
        end
        else if (taken_reg)
        begin
          pc_next    = pc_reg + branchOffset;
          instr_next = OPC_NOP;
        end
        else if (skip_reg)
        begin
          instr_next      = OPC_NOP;
          skipSecond_next = isTwoWord(progData);
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phase_reg      <= PH_Q1;
      pc_reg         <= PC_RESET;
      instr_reg      <= OPC_NOP;
      acc_reg        <= DATA_ZERO;
      status_reg     <= STATUS_RESET;
      bank_reg       <= BANK_RESET;
      extEn_reg      <= 1'b0;
      accSh_reg      <= DATA_ZERO;
      statusSh_reg   <= STATUS_RESET;
      bankSh_reg     <= BANK_RESET;
      timeout_reg    <= 1'b1;
      powerdown_reg  <= 1'b1;
      taken_reg      <= 1'b0;
      skip_reg       <= 1'b0;
      skipSecond_reg <= 1'b0;
      dataAddr_reg   <= '0;
      dataWrite_reg  <= '0;
      push_reg       <= '0;
      wdtClear_reg   <= 1'b0;
    end
    else
    begin
      phase_reg      <= phase_next;
      pc_reg         <= pc_next;
      instr_reg      <= instr_next;
      acc_reg        <= acc_next;
      status_reg     <= status_next;
      bank_reg       <= bank_next;
      extEn_reg      <= extEn_next;
      accSh_reg      <= accSh_next;
      statusSh_reg   <= statusSh_next;
      bankSh_reg     <= bankSh_next;
      timeout_reg    <= timeout_next;
      powerdown_reg  <= powerdown_next;
      taken_reg      <= taken_next;
      skip_reg       <= skip_next;
      skipSecond_reg <= skipSecond_next;
      dataAddr_reg   <= dataAddr_next;
      dataWrite_reg  <= dataWrite_next;
      push_reg       <= push_next;
      wdtClear_reg   <= wdtClear_next;
    end
  end

  // ****************************************
  // register port read
  // ****************************************
  always_comb
  begin
    regRdata_next = DATA_ZERO;
    if (regRd)
    begin
      unique case (regAddr)
        REG_ACC:       regRdata_next = acc_reg;
        REG_STATUS:    regRdata_next = {3'h0, status_reg};
        REG_BANK:      regRdata_next = {4'h0, bank_reg};
        REG_CTRL:      regRdata_next = {7'h00, extEn_reg};
        REG_ACC_SH:    regRdata_next = accSh_reg;
        REG_STATUS_SH: regRdata_next = {3'h0, statusSh_reg};
        REG_BANK_SH:   regRdata_next = {4'h0, bankSh_reg};
        REG_WDT_FLAGS: regRdata_next = {6'h00, timeout_reg, powerdown_reg};
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      regRdata_reg <= DATA_ZERO;
    end
    else
    begin
      regRdata_reg <= regRdata_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign progAddr  = pc_reg;
  assign dataAddr  = dataAddr_reg;
  assign dataWrite = dataWrite_reg;
  assign stackPush = push_reg;
  assign wdtClear  = wdtClear_reg;
  assign regRdata  = regRdata_reg;

endmodule : bcc_core_exec

/* File: bench/bcc_core_exec_assertions.sv */
`timescale 1ns/1ps
module bcc_core_exec_assertions
  import bcc_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        sys_rst,
  input wire logic [bcc_pkg::PC_W-1:0]    progAddr,
  input wire logic [bcc_pkg::WORD_W-1:0]  progData,
  input wire logic [bcc_pkg::DADDR_W-1:0] dataAddr,
  input wire bcc_pkg::bcc_dwrite_t        dataWrite,
  input wire bcc_pkg::bcc_push_t          stackPush,
  input wire logic                        wdtClear,
  input wire logic                        regRd,
  input wire logic [bcc_pkg::DATA_W-1:0]  regRdata
);
  import bcc_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  logic [11:0] targetHi;

  assign targetHi = progData[11:0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ****************************************
  // sequences
  // ****************************************
  sequence s_call_push;
    stackPush.push;
  endsequence

  sequence s_quiet_cycle;
    (!dataWrite.we && !wdtClear && !stackPush.push) [*4];
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  a_push_ret_addr: assert property (s_call_push |-> stackPush.addr == progAddr + PC_STEP)
    else $error("call pushed a wrong return address");
  a_call_target_hi: assert property (s_call_push |=> progAddr[20:9] == $past(targetHi))
    else $error("call target upper bits not taken from second word");
  a_call_nop_cycle: assert property (s_call_push |=> s_quiet_cycle)
    else $error("cycle after call is not a no-operation");
  a_pc_even: assert property (progAddr[0] == 1'b0)
    else $error("program address is odd");
  a_pc_stands: assert property ($changed(progAddr) |=> $stable(progAddr) [*3])
    else $error("program address changed inside an instruction cycle");
  a_wdt_pulse: assert property (wdtClear |=> !wdtClear [*3])
    else $error("watchdog clear longer than one pulse per cycle");
  a_write_pulse: assert property (dataWrite.we |=> !dataWrite.we [*3])
    else $error("more than one data write per instruction cycle");
  a_write_addr: assert property (dataWrite.we |-> dataWrite.addr == dataAddr)
    else $error("data write address differs from operand address");
  a_read_quiet: assert property (!regRd |=> regRdata == 8'h00)
    else $error("register read data not zero outside read answer");

  c_call: cover property (s_call_push);
  c_wdt: cover property (wdtClear);
endmodule : bcc_core_exec_assertions

bind bcc_core_exec bcc_core_exec_assertions u_bcc_core_exec_assertions (
  .clk      (clk),
  .sys_rst  (sys_rst),
  .progAddr (progAddr),
  .progData (progData),
  .dataAddr (dataAddr),
  .dataWrite(dataWrite),
  .stackPush(stackPush),
  .wdtClear (wdtClear),
  .regRd    (regRd),
  .regRdata (regRdata)
);

/* File: bench/bcc_core_exec_bench.sv */
`timescale 1ns/1ps
module bcc_core_exec_bench;
  import bcc_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  logic               clk = 1'b0;
  logic               sys_rst;
  logic [PC_W-1:0]    progAddr;
  logic [WORD_W-1:0]  progData;
  logic [DADDR_W-1:0] dataAddr;
  logic [DATA_W-1:0]  dataRdata;
  bcc_dwrite_t        dataWrite;
  logic [DADDR_W-1:0] indexBase;
  bcc_push_t          stackPush;
  logic               wdtClear;
  logic [RADDR_W-1:0] regAddr;
  logic [DATA_W-1:0]  regWdata;
  logic               regWr;
  logic               regRd;
  logic [DATA_W-1:0]  regRdata;
  logic [WORD_W-1:0]  prog [0:63];
  logic [DATA_W-1:0]  dmem [0:4095];
  logic [PC_W-1:0]    pushAddr;
  int                 badCount;
  int                 checks;
  int                 cyc;
  int                 pushCount;
  int                 wdtCount;
  int                 weCount;

  // program from byte address 0x04; two leading no-ops let register setup land
  localparam logic [15:0] CODE [0:16] = '{16'h6305, 16'h6A20, 16'h6480, 16'hEC40,
    16'hF000, 16'h6105, 16'h6A21, 16'hE002, 16'h6A22, 16'h6A23, 16'h1E10,
    16'hE005, 16'h0004, 16'h1D05, 16'hED20, 16'hF000, 16'h6A25};
  localparam int          STOP_K [0:4] = '{8, 12, 15, 18, 21};
  localparam logic [20:0] STOP_PC [0:4] = '{21'h0_000E, 21'h0_0018, 21'h0_001E,
    21'h0_0040, 21'h0_0046};

  assign progData  = prog[progAddr[6:1]];
  assign dataRdata = dmem[dataAddr];

  always #4 clk = ~clk;

  bcc_core_exec u_bcc_core_exec (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .progAddr (progAddr),
    .progData (progData),
    .dataAddr (dataAddr),
    .dataRdata(dataRdata),
    .dataWrite(dataWrite),
    .indexBase(indexBase),
    .stackPush(stackPush),
    .wdtClear (wdtClear),
    .regAddr  (regAddr),
    .regWdata (regWdata),
    .regWr    (regWr),
    .regRd    (regRd),
    .regRdata (regRdata)
  );

  // ****************************************
  // memory and pulse monitor
  // ****************************************
  always @(posedge clk)
  begin
    if (!sys_rst)
    begin
      cyc <= cyc + 1;
      if (stackPush.push === 1'b1)
      begin
        pushCount <= pushCount + 1;
        pushAddr  <= stackPush.addr;
      end
      if (wdtClear === 1'b1)
        wdtCount <= wdtCount + 1;
      if (dataWrite.we === 1'b1)
      begin
        weCount <= weCount + 1;
        dmem[dataWrite.addr] <= dataWrite.data;
      end
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    checks++;
    if (got !== exp)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chkAddr(input string name, input logic [PC_W-1:0] exp,
                         input logic [PC_W-1:0] got);
    checks++;
    if (got !== exp)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chkAddr

  task automatic regWrite(input logic [RADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : regWrite

  task automatic rdChk(input string name, input logic [RADDR_W-1:0] a,
                       input logic [DATA_W-1:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    @(negedge clk);
    chk(name, exp, regRdata);
  endtask : rdChk

  task automatic waitCyc(input int n);
    while (cyc < n)
      @(posedge clk);
    @(negedge clk);
  endtask : waitCyc

  task automatic finalReport();
    if (badCount == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finalReport

  // ****************************************
  // watchdog
  // ****************************************
  initial
  begin
    repeat (3000) @(posedge clk);
    badCount++;
    finalReport();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    sys_rst = 1'b1;
    regAddr = 3'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    indexBase = 12'h200;
    badCount = 0;
    checks = 0;
    cyc = 0;
    pushCount = 0;
    wdtCount = 0;
    weCount = 0;
    foreach (prog[i])
      prog[i] = 16'h0000;
    foreach (CODE[i])
      prog[i + 2] = CODE[i];
    prog[32] = 16'h6080;
    prog[33] = 16'h6A24;
    // clear with indexing switched off, reached late in the run
    prog[48] = 16'h6A26;
    foreach (dmem[i])
      dmem[i] = 8'h00;
    dmem[12'h305] = 8'h5A;
    dmem[12'h210] = 8'h13;
    dmem[12'hF80] = 8'h77;
    dmem[12'h220] = 8'h11;
    dmem[12'h221] = 8'h33;
    dmem[12'h222] = 8'h22;
    dmem[12'h223] = 8'h23;
    dmem[12'h224] = 8'h24;
    dmem[12'h225] = 8'h25;
    dmem[12'h026] = 8'h99;
    dmem[12'h226] = 8'h26;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    regWrite(REG_CTRL, 8'h01);
    regWrite(REG_ACC, 8'h5A);
    regWrite(REG_BANK, 8'h03);
    regWrite(REG_WDT_FLAGS, 8'h00);
    rdChk("flags after write", REG_WDT_FLAGS, 8'h03);
    rdChk("acc shadow reset", REG_ACC_SH, 8'h00);
    rdChk("bank shadow reset", REG_BANK_SH, 8'h00);
    foreach (STOP_K[i])
    begin
      waitCyc(4 * STOP_K[i] - 2);
      chkAddr("program address", STOP_PC[i], progAddr);
    end
    waitCyc(100);
    chk("skipped equal target", 8'h11, dmem[12'h220]);
    chk("cleared register", 8'h00, dmem[12'h221]);
    chk("branch skipped word 1", 8'h22, dmem[12'h222]);
    chk("branch skipped word 2", 8'h23, dmem[12'h223]);
    chk("skipped less target", 8'h24, dmem[12'h224]);
    chk("word after call", 8'h25, dmem[12'h225]);
    chk("inverted register", 8'hEC, dmem[12'h210]);
    chk("compared register", 8'h5A, dmem[12'h305]);
    chk("write count", 8'h02, 8'(weCount));
    chk("push count", 8'h01, 8'(pushCount));
    chkAddr("return address", 21'h0_0024, pushAddr);
    chk("watchdog clears", 8'h01, 8'(wdtCount));
    regWrite(REG_CTRL, 8'h00);
    rdChk("accumulator", REG_ACC, 8'hA5);
    rdChk("status", REG_STATUS, 8'h10);
    rdChk("acc shadow", REG_ACC_SH, 8'hA5);
    rdChk("status shadow", REG_STATUS_SH, 8'h10);
    rdChk("bank shadow", REG_BANK_SH, 8'h03);
    rdChk("bank select", REG_BANK, 8'h03);
    rdChk("watchdog flags", REG_WDT_FLAGS, 8'h03);
    waitCyc(150);
    chk("low access bank clear", 8'h00, dmem[12'h026]);
    chk("indexed target untouched", 8'h26, dmem[12'h226]);
    finalReport();
  end
endmodule : bcc_core_exec_bench
